//--- hdl/sdram_cfg_pkg.sv
// Purpose: Shared constants, types and lookups for the SDRAM timing and size configuration.
// Assumes: One 250 MHz clock, 32-bit APB register access, eight memory blocks.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package sdram_cfg_pkg;

	localparam int NUM_BLOCKS = 8;
	localparam int BLOCK_SEL_W = 3;
	localparam int BANK_COUNT = 4;
	localparam int LOCATION_BYTES = 8;
	localparam int BYTE_ADDR_BITS = 3;
	localparam int BASE_LSB = 25;
	localparam int BASE_W = 7;
	localparam int ROW_W = 13;
	localparam int COL_W = 11;

	localparam logic [7:0] OFF_SPEED = 8'h00;
	localparam logic [7:0] OFF_CLKDIV = 8'h04;
	localparam logic [7:0] OFF_USEC = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [2:0] OFF_BLOCK_PAGE = 3'h1;

	localparam int CTRL_SCRUB_EN_BIT = 0;
	localparam int CTRL_REFRESH_DIS_BIT = 1;
	localparam int BLK_SIZE_LSB = 0;
	localparam int BLK_ENABLE_BIT = 4;
	localparam int STAT_SCRUB_LSB = 16;
	localparam int STAT_STATE_LSB = 20;

	localparam int TRAS_BASE_CLOCKS = 4;
	localparam int TRP_BASE_CLOCKS = 2;
	localparam int TRCD_BASE_CLOCKS = 2;
	localparam int TRC_WRAP_CLOCKS = 8;

	localparam int CLK_PERIOD_NS = 4;
	localparam int NS_PER_USEC = 1000;
	localparam int CLKS_PER_USEC = NS_PER_USEC / CLK_PERIOD_NS;
	localparam logic [7:0] CLKDIV_RESET = 8'(CLKS_PER_USEC - 1);
	localparam logic [7:0] REFRESH_INTERVAL_US = 8'h07;
	localparam logic [3:0] SIZE_NONE = 4'h0;
	localparam logic [3:0] SIZE_MAX = 4'h9;

	typedef struct packed {
		logic cas_latency_three;
		logic [2:0] trc;
		logic trcd;
		logic trp;
		logic [1:0] tras;
	} timing_type;

	// Slowest settings: 7 clocks active, 3 precharge, 3 row-to-column, 11 row cycle, latency 3.
	localparam timing_type TIMING_RESET = '{1'b1, 3'b011, 1'b1, 1'b1, 2'b11};

	typedef struct packed {
		logic hit;
		logic [1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} xlate_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRECHARGE = 2'b01,
		ST_REFRESH = 2'b11,
		ST_SCRUB = 2'b10
	} refresh_state_type;

	// Row and column address widths of one device for each size code; bank bits are always two.
	function automatic logic [3:0] size_rows(input logic [3:0] code);
		unique case (code)
			4'h6, 4'h8, 4'h9: size_rows = 4'hd;
			default: size_rows = 4'hc;
		endcase
	endfunction

	function automatic logic [3:0] size_cols(input logic [3:0] code);
		unique case (code)
			4'h1: size_cols = 4'h8;
			4'h2, 4'h3, 4'h6: size_cols = 4'h9;
			4'h4, 4'h5, 4'h8: size_cols = 4'ha;
			default: size_cols = 4'hb;
		endcase
	endfunction

	// Codes 100 and 101 are unsupported and fall back to the slowest cycle.
	function automatic logic [3:0] trc_clocks(input logic [2:0] code);
		if (code[2] && code[1])
			trc_clocks = {1'b0, code};
		else if (code[2])
			trc_clocks = 4'hb;
		else
			trc_clocks = 4'(TRC_WRAP_CLOCKS) + {1'b0, code};
	endfunction

endpackage

//--- hdl/usec_counter.sv
// Purpose: Free-running counter that advances once per microsecond.
// Assumes: Divider holds clocks per microsecond minus one.
// Notes: A software load wins over the increment in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module usec_counter
	import sdram_cfg_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic [7:0] clk_div,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	// Result
	output logic [WIDTH-1:0] count,
	output logic tick
);
	logic [7:0] prescale_r, prescale_nxt;
	logic [WIDTH-1:0] count_r, count_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		tick_nxt = (prescale_r >= clk_div);
		prescale_nxt = tick_nxt ? 8'h00 : prescale_r + 8'h01;
		count_nxt = count_r;
		if (load)
			count_nxt = load_value;
		else if (tick_nxt)
			count_nxt = count_r + WIDTH'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prescale_r <= 8'h00;
			count_r <= '0;
			tick_r <= 1'b0;
		end else begin
			prescale_r <= prescale_nxt;
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign count = count_r;
	assign tick = tick_r;
endmodule
`default_nettype wire

//--- hdl/block_decoder.sv
// Purpose: Decodes one block's address range and maps a bus address to bank, row and column.
// Assumes: Four internal banks and eight-byte locations.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module block_decoder
	import sdram_cfg_pkg::*;
(
	// Block configuration
	input wire logic [3:0] size,
	input wire logic enable,
	input wire logic [BASE_W-1:0] base,
	// Address in and result out
	input wire logic [31:0] addr,
	output xlate_type xlate
);
	logic [3:0] rows;
	logic [3:0] cols;
	logic [2:0] span;
	logic [BASE_W-1:0] mask;
	logic [31:0] word;
	logic [31:0] upper;

	always_comb begin
		rows = size_rows(size);
		cols = size_cols(size);
		// Span above the 32MB minimum; block bytes are locations times eight.
		span = 3'(5'(rows) + 5'(cols) + 5'd2 + 5'(BYTE_ADDR_BITS) - 5'(BASE_LSB));
		mask = BASE_W'(7'h7f << span);
		word = addr >> BYTE_ADDR_BITS;
		upper = word >> cols;
		xlate.hit = enable && (size != SIZE_NONE) && (size <= SIZE_MAX)
			&& (((addr[31:BASE_LSB] ^ base) & mask) == '0);
		xlate.col = COL_W'(word & ((32'h1 << cols) - 32'h1));
		xlate.bank = upper[1:0];
		xlate.row = ROW_W'((upper >> 2) & ((32'h1 << rows) - 32'h1));
	end
endmodule
`default_nettype wire

//--- hdl/sdram_timing_size_config.sv
// Purpose: Timing and size configuration, address decode, refresh and scrub scheduling.
// Assumes: APB slave with no wait cycles; inputs synchronous to ref_clk.
// Notes: Timing changes reach the sequencer only between refresh operations.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Timing fields reset to slowest settings.
// - Block size codes reset to zero.
// - Size code drives decode and address mapping.
// - Nonzero-size blocks join scrubbing when scrub is enabled, whatever their block enable bit.
// - Active time code gives 4 to 7.
// - Precharge code gives 2 or 3 clocks.
// - Row-to-column code gives 2 or 3 clocks.
// - Row cycle codes give 6 to 11.
// - Size codes map to documented geometries.
// - Block bytes equal locations times eight.
// - Only four-bank devices are supported.
// - Config writes during refresh stay harmless.
// - Thirty-two bit microsecond counter, cleared on reset.
module sdram_timing_size_config
	import sdram_cfg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Address translation
	input wire logic [31:0] cpu_addr,
	output xlate_type xlate_r,
	output logic [BLOCK_SEL_W-1:0] hit_block_r,
	// Effective timing in clocks
	output logic [3:0] tras_clocks_r,
	output logic [3:0] trp_clocks_r,
	output logic [3:0] trcd_clocks_r,
	output logic [3:0] trc_clocks_r,
	output logic cas_latency_three_r,
	// Refresh and scrub commands
	output logic precharge_cmd_r,
	output logic refresh_cmd_r,
	output logic scrub_cmd_r,
	output logic [BLOCK_SEL_W-1:0] scrub_block_r,
	output logic [NUM_BLOCKS-1:0] refresh_blocks_r
);
	// Register file.
	timing_type speed_r, speed_nxt;
	timing_type active_r, active_nxt;
	logic [7:0] clk_div_r, clk_div_nxt;
	logic scrub_en_r, scrub_en_nxt;
	logic refresh_dis_r, refresh_dis_nxt;
	logic [3:0] size_r [NUM_BLOCKS];
	logic [3:0] size_nxt [NUM_BLOCKS];
	logic enable_r [NUM_BLOCKS];
	logic enable_nxt [NUM_BLOCKS];
	logic [BASE_W-1:0] base_r [NUM_BLOCKS];
	logic [BASE_W-1:0] base_nxt [NUM_BLOCKS];
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic wr_take;
	logic blk_sel;
	logic [BLOCK_SEL_W-1:0] blk_idx;
	logic usec_load;
	logic [31:0] usec_count;
	logic usec_tick;

	// Refresh sequencer.
	refresh_state_type state_r, state_nxt;
	logic [3:0] timer_r, timer_nxt;
	logic [7:0] interval_r, interval_nxt;
	logic pending_r, pending_nxt;
	logic [15:0] refresh_count_r, refresh_count_nxt;
	logic [BLOCK_SEL_W-1:0] scrub_ptr_r, scrub_ptr_nxt;
	logic scrub_found;
	logic [BLOCK_SEL_W-1:0] scrub_next;

	// Translation.
	xlate_type dec [NUM_BLOCKS];
	xlate_type xlate_nxt;
	logic [BLOCK_SEL_W-1:0] hit_block_nxt;
	logic [NUM_BLOCKS-1:0] enabled_mask;

	assign blk_sel = (paddr[7:5] == OFF_BLOCK_PAGE) && (paddr[1:0] == 2'b00);
	assign blk_idx = paddr[4:2];
	assign wr_take = psel && penable && pready_r && pwrite;
	assign usec_load = wr_take && (paddr == OFF_USEC);

	usec_counter #(.WIDTH(32)) u_usec (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_div(clk_div_r),
		.load(usec_load),
		.load_value(pwdata),
		.count(usec_count),
		.tick(usec_tick)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_BLOCKS; g++) begin : gen_block
			block_decoder u_dec (
				.size(size_r[g]),
				.enable(enable_r[g]),
				.base(base_r[g]),
				.addr(cpu_addr),
				.xlate(dec[g])
			);
			assign enabled_mask[g] = enable_r[g] && (size_r[g] != SIZE_NONE);
		end
	endgenerate

	// APB access: the answer is prepared in the setup cycle, so the access phase takes one cycle.
	always_comb begin
		speed_nxt = speed_r;
		clk_div_nxt = clk_div_r;
		scrub_en_nxt = scrub_en_r;
		refresh_dis_nxt = refresh_dis_r;
		size_nxt = size_r;
		enable_nxt = enable_r;
		base_nxt = base_r;
		pready_nxt = psel && !penable;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (paddr == OFF_SPEED)
				prdata_nxt = {24'h00_0000, speed_r};
			else if (paddr == OFF_CLKDIV)
				prdata_nxt = {24'h00_0000, clk_div_r};
			else if (paddr == OFF_USEC)
				prdata_nxt = usec_count;
			else if (paddr == OFF_CTRL)
				prdata_nxt = {30'h0, refresh_dis_r, scrub_en_r};
			else if (paddr == OFF_STATUS)
				prdata_nxt = {10'h000, state_r, 1'b0, scrub_ptr_r, refresh_count_r};
			else if (blk_sel)
				prdata_nxt = {base_r[blk_idx], 20'h0_0000, enable_r[blk_idx], size_r[blk_idx]};
			else
				pslverr_nxt = 1'b1;
		end
		if (wr_take) begin
			if (paddr == OFF_SPEED)
				speed_nxt = timing_type'(pwdata[7:0]);
			else if (paddr == OFF_CLKDIV)
				clk_div_nxt = pwdata[7:0];
			else if (paddr == OFF_CTRL) begin
				scrub_en_nxt = pwdata[CTRL_SCRUB_EN_BIT];
				refresh_dis_nxt = pwdata[CTRL_REFRESH_DIS_BIT];
			end else if (blk_sel) begin
				size_nxt[blk_idx] = pwdata[BLK_SIZE_LSB +: 4];
				enable_nxt[blk_idx] = pwdata[BLK_ENABLE_BIT];
				base_nxt[blk_idx] = pwdata[31:BASE_LSB];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			speed_r <= TIMING_RESET;
			clk_div_r <= CLKDIV_RESET;
			scrub_en_r <= 1'b0;
			refresh_dis_r <= 1'b0;
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				size_r[i] <= SIZE_NONE;
				enable_r[i] <= 1'b0;
				base_r[i] <= '0;
			end
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			speed_r <= speed_nxt;
			clk_div_r <= clk_div_nxt;
			scrub_en_r <= scrub_en_nxt;
			refresh_dis_r <= refresh_dis_nxt;
			size_r <= size_nxt;
			enable_r <= enable_nxt;
			base_r <= base_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Next block after the scrub pointer that has a nonzero size.
	always_comb begin
		scrub_found = 1'b0;
		scrub_next = scrub_ptr_r;
		for (int i = NUM_BLOCKS; i >= 1; i--) begin
			if (size_r[BLOCK_SEL_W'(scrub_ptr_r + BLOCK_SEL_W'(i))] != SIZE_NONE) begin
				scrub_found = 1'b1;
				scrub_next = BLOCK_SEL_W'(scrub_ptr_r + BLOCK_SEL_W'(i));
			end
		end
	end

	// Timing is taken from the register only while idle, so a write never bends a running cycle.
	always_comb begin
		state_nxt = state_r;
		timer_nxt = (timer_r != 4'h0) ? timer_r - 4'h1 : 4'h0;
		interval_nxt = interval_r;
		pending_nxt = pending_r;
		active_nxt = active_r;
		refresh_count_nxt = refresh_count_r;
		scrub_ptr_nxt = scrub_ptr_r;
		if (usec_tick) begin
			if (interval_r >= REFRESH_INTERVAL_US - 8'h01) begin
				interval_nxt = 8'h00;
				pending_nxt = !refresh_dis_r;
			end else
				interval_nxt = interval_r + 8'h01;
		end
		unique case (state_r)
			ST_IDLE: begin
				active_nxt = speed_r;
				if (pending_r) begin
					state_nxt = ST_PRECHARGE;
					timer_nxt = 4'(TRP_BASE_CLOCKS) + {3'b000, speed_r.trp} - 4'h1;
					pending_nxt = 1'b0;
				end
			end
			ST_PRECHARGE: if (timer_r == 4'h0) begin
				state_nxt = ST_REFRESH;
				timer_nxt = trc_clocks(active_r.trc) - 4'h1;
			end
			ST_REFRESH: if (timer_r == 4'h0) begin
				refresh_count_nxt = refresh_count_r + 16'h0001;
				if (scrub_en_r && scrub_found) begin
					state_nxt = ST_SCRUB;
					scrub_ptr_nxt = scrub_next;
					timer_nxt = trc_clocks(active_r.trc) - 4'h1;
				end else
					state_nxt = ST_IDLE;
			end
			ST_SCRUB: if (timer_r == 4'h0)
				state_nxt = ST_IDLE;
		endcase
		// A refresh that falls due while the last one is being taken is kept, not dropped.
		if (usec_tick && interval_r >= REFRESH_INTERVAL_US - 8'h01 && !refresh_dis_r)
			pending_nxt = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			timer_r <= 4'h0;
			interval_r <= 8'h00;
			pending_r <= 1'b0;
			active_r <= TIMING_RESET;
			refresh_count_r <= 16'h0000;
			scrub_ptr_r <= '0;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			interval_r <= interval_nxt;
			pending_r <= pending_nxt;
			active_r <= active_nxt;
			refresh_count_r <= refresh_count_nxt;
			scrub_ptr_r <= scrub_ptr_nxt;
		end
	end

	// First matching block wins; overlapping bases are a software fault.
	always_comb begin
		xlate_nxt = '0;
		hit_block_nxt = '0;
		for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
			if (dec[i].hit) begin
				xlate_nxt = dec[i];
				hit_block_nxt = BLOCK_SEL_W'(i);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			xlate_r <= '0;
			hit_block_r <= '0;
			tras_clocks_r <= 4'(TRAS_BASE_CLOCKS) + 4'h3;
			trp_clocks_r <= 4'(TRP_BASE_CLOCKS) + 4'h1;
			trcd_clocks_r <= 4'(TRCD_BASE_CLOCKS) + 4'h1;
			trc_clocks_r <= 4'hb;
			cas_latency_three_r <= 1'b1;
			precharge_cmd_r <= 1'b0;
			refresh_cmd_r <= 1'b0;
			scrub_cmd_r <= 1'b0;
			scrub_block_r <= '0;
			refresh_blocks_r <= '0;
		end else begin
			xlate_r <= xlate_nxt;
			hit_block_r <= hit_block_nxt;
			tras_clocks_r <= 4'(TRAS_BASE_CLOCKS) + {2'b00, active_r.tras};
			trp_clocks_r <= 4'(TRP_BASE_CLOCKS) + {3'b000, active_r.trp};
			trcd_clocks_r <= 4'(TRCD_BASE_CLOCKS) + {3'b000, active_r.trcd};
			trc_clocks_r <= trc_clocks(active_r.trc);
			cas_latency_three_r <= active_r.cas_latency_three;
			precharge_cmd_r <= (state_nxt == ST_PRECHARGE) && (state_r == ST_IDLE);
			refresh_cmd_r <= (state_nxt == ST_REFRESH) && (state_r == ST_PRECHARGE);
			scrub_cmd_r <= (state_nxt == ST_SCRUB) && (state_r == ST_REFRESH);
			scrub_block_r <= scrub_ptr_nxt;
			refresh_blocks_r <= enabled_mask;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule
`default_nettype wire

//--- verif/sdram_model.sv
// Purpose: Memory-side model that watches refresh and scrub traffic.
// Assumes: Commands are one-cycle pulses from the controller.
// Notes: Banks start open, since a device out of reset may hold any row.
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Commands
	input wire logic precharge_cmd,
	input wire logic refresh_cmd,
	input wire logic scrub_cmd,
	// Observation
	output int refresh_seen,
	output logic bad_order
);
	logic [3:0] bank_open_r;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_open_r <= 4'hf;
			refresh_seen <= 0;
			bad_order <= 1'b0;
		end else if (precharge_cmd) begin
			bank_open_r <= 4'h0;
		end else if (refresh_cmd) begin
			// A refresh onto an open bank would lose its row.
			bad_order <= bad_order | (|bank_open_r);
			refresh_seen <= refresh_seen + 1;
		end else if (scrub_cmd) begin
			bank_open_r <= 4'hf;
		end
	end
endmodule
`default_nettype wire

//--- verif/sdram_timing_size_config_props.sv
// Purpose: Port-level checks of the configuration block.
// Assumes: One clock domain with synchronous reset.
// Notes: The gap counter saturates, so long idle spans read as fifteen.
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_props
	import sdram_cfg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Results
	input wire xlate_type xlate_r,
	input wire logic [3:0] tras_clocks_r,
	input wire logic [3:0] trp_clocks_r,
	input wire logic [3:0] trcd_clocks_r,
	input wire logic [3:0] trc_clocks_r,
	input wire logic cas_latency_three_r,
	input wire logic precharge_cmd_r,
	input wire logic refresh_cmd_r,
	input wire logic scrub_cmd_r,
	input wire logic [NUM_BLOCKS-1:0] refresh_blocks_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [3:0] gap_r;
	logic [3:0] gap_nxt;
	always_comb begin
		gap_nxt = gap_r;
		if (refresh_cmd_r) begin
			gap_nxt = 4'h1;
		end else if (gap_r != 4'hf) begin
			gap_nxt = gap_r + 4'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		gap_r <= rst ? 4'hf : gap_nxt;
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_pre_hold;
		!refresh_cmd_r [*3] ##1 refresh_cmd_r;
	endsequence
	a_apb_answer: assert property (s_setup |=> psel && penable && pready)
		else $error("setup not answered in the next cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_reset_slow: assert property ($fell(rst) |-> tras_clocks_r == 4'h7 &&
		trp_clocks_r == 4'h3 && trcd_clocks_r == 4'h3 && trc_clocks_r == 4'hb
		&& cas_latency_three_r) else $error("timing not slowest after reset");
	a_reset_sizes: assert property ($fell(rst) |-> refresh_blocks_r == 8'h00)
		else $error("block mask not clear after reset");
	a_precharge_gap: assert property (precharge_cmd_r && trp_clocks_r == 4'h3 |-> s_pre_hold)
		else $error("refresh spacing after precharge wrong");
	a_row_cycle: assert property ((scrub_cmd_r || precharge_cmd_r) |->
		gap_r >= trc_clocks_r) else $error("row cycle too short");
	a_no_block_hit: assert property (refresh_blocks_r == 8'h00 &&
		$past(refresh_blocks_r) == 8'h00 |-> !xlate_r.hit) else $error("hit with no block");
	a_cmd_single: assert property (refresh_cmd_r |=> !refresh_cmd_r &&
		!precharge_cmd_r) else $error("refresh pulse malformed");
endmodule
bind sdram_timing_size_config sdram_cfg_props props_u (.ref_clk, .rst, .psel, .penable,
	.pready, .pslverr, .xlate_r, .tras_clocks_r, .trp_clocks_r, .trcd_clocks_r, .trc_clocks_r,
	.cas_latency_three_r, .precharge_cmd_r, .refresh_cmd_r, .scrub_cmd_r, .refresh_blocks_r);
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the SDRAM timing and size configuration.
// Assumes: APB answers after one access cycle.
// Notes: The divider is lowered so that refresh comes every 28 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top
	import sdram_cfg_pkg::*;
;
	typedef struct packed {
		logic [7:0] spd;
		logic [15:0] tim;
		logic c3;
		logic [3:0] siz;
	} row_type;
	// Each row is timing fitted to the slowest block, latency three set where needed.
	// Timing comes from nanoseconds over the bus period; row 0 is the 4Mx16 scratch.
	row_type rows [10] = '{'{8'h60, 16'h4226, 1'b0, 4'h1}, '{8'hf9, 16'h5237, 1'b1, 4'h2},
		'{8'h06, 16'h6328, 1'b0, 4'h3}, '{8'h9f, 16'h7339, 1'b1, 4'h4},
		'{8'h20, 16'h422a, 1'b0, 4'h5}, '{8'hbf, 16'h733b, 1'b1, 4'h6},
		'{8'h60, 16'h4226, 1'b0, 4'h7}, '{8'hf9, 16'h5237, 1'b1, 4'h8},
		'{8'h06, 16'h6328, 1'b0, 4'h9}, '{8'h9f, 16'h7339, 1'b1, 4'ha}};
	int rw [10] = '{0, 12, 12, 12, 12, 12, 13, 12, 13, 13};
	int cw [10] = '{0, 8, 9, 9, 10, 10, 9, 11, 10, 11};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
	logic [7:0] paddr = 8'h00;
	logic [7:0] refresh_blocks_r;
	logic [31:0] pwdata = '0, cpu_addr = 32'h01234568, prdata, q;
	logic [3:0] tras_clocks_r, trp_clocks_r, trcd_clocks_r, trc_clocks_r;
	logic cas_latency_three_r, precharge_cmd_r, refresh_cmd_r, scrub_cmd_r, bad;
	logic [2:0] hit_block_r, scrub_block_r, sb0;
	xlate_type xlate_r, ex;
	int errors = 0, check_count = 0, seen, n, i;
	sdram_timing_size_config dut_u (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .cpu_addr, .xlate_r, .hit_block_r,
		.tras_clocks_r, .trp_clocks_r, .trcd_clocks_r, .trc_clocks_r, .cas_latency_three_r,
		.precharge_cmd_r, .refresh_cmd_r, .scrub_cmd_r, .scrub_block_r, .refresh_blocks_r);
	sdram_model mem_u (.ref_clk, .rst, .precharge_cmd(precharge_cmd_r),
		.refresh_cmd(refresh_cmd_r), .scrub_cmd(scrub_cmd_r), .refresh_seen(seen),
		.bad_order(bad));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic end_of_test();
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wait_scrub();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (scrub_cmd_r !== 1'b1 && k < 200);
		if (k >= 200) begin
			errors++;
			end_of_test();
		end
	endtask
	// Column, bank, then row, above the eight-byte location offset.
	function automatic xlate_type expect_x(input logic [3:0] s, input logic [31:0] a);
		logic [31:0] w;
		w = a >> 3;
		expect_x = '0;
		if (s <= 4'h9) begin
			expect_x.hit = 1'b1;
			expect_x.col = COL_W'(w & ((32'h1 << cw[s]) - 1));
			expect_x.bank = 2'(w >> cw[s]);
			expect_x.row = ROW_W'((w >> (cw[s] + 2)) & ((32'h1 << rw[s]) - 1));
		end
	endfunction
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 10; i++) begin
			apb(1'b1, OFF_SPEED, {24'h0, rows[i].spd});
			apb(1'b1, 8'h20, {27'h0, 1'b1, rows[i].siz});
			repeat (40) @(posedge ref_clk);
			ex = expect_x(rows[i].siz, cpu_addr);
			`CHK("timing", rows[i].tim, {tras_clocks_r, trp_clocks_r, trcd_clocks_r, trc_clocks_r})
			`CHK("cas3", rows[i].c3, cas_latency_three_r)
			`CHK("hit", ex.hit, xlate_r.hit)
			if (ex.hit) `CHK("map", ex, xlate_r)
			if (ex.hit) `CHK("blk", 3'h0, hit_block_r)
		end
		apb(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 33'h100000000, {e, q})
		apb(1'b1, 8'h02, 32'h1);
		`CHK("misaligned", 1'b1, e)
		apb(1'b1, OFF_CLKDIV, 32'h3);
		apb(1'b1, 8'h20, 32'h0);
		apb(1'b1, 8'h28, 32'h13);
		apb(1'b1, 8'h34, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h1);
		wait_scrub();
		sb0 = scrub_block_r;
		`CHK("scrub0", 1'b1, (sb0 == 3'h2 || sb0 == 3'h5))
		wait_scrub();
		`CHK("scrub1", 3'h7, sb0 ^ scrub_block_r)
		`CHK("mask", 8'h04, refresh_blocks_r)
		`CHK("order", 1'b0, bad)
		apb(1'b1, OFF_USEC, 32'h100);
		apb(1'b0, OFF_USEC, 32'h0);
		n = q;
		`CHK("usec_wr", 1'b1, n >= 32'h100 && n <= 32'h102)
		repeat (40) @(posedge ref_clk);
		apb(1'b0, OFF_USEC, 32'h0);
		`CHK("usec_run", 1'b1, q - n >= 9 && q - n <= 12)
		apb(1'b1, OFF_CTRL, 32'h2);
		// A refresh already under way when the disable lands may still finish.
		repeat (20) @(posedge ref_clk);
		n = seen;
		repeat (100) @(posedge ref_clk);
		`CHK("refdis", n, seen)
		apb(1'b1, 8'h28, 32'h0400_0013);
		cpu_addr <= 32'h0523_4568;
		repeat (2) @(posedge ref_clk);
		ex = expect_x(4'h3, cpu_addr);
		`CHK("base_in", ex, xlate_r)
		`CHK("base_blk", 3'h2, hit_block_r)
		cpu_addr <= 32'h0923_4568;
		repeat (2) @(posedge ref_clk);
		`CHK("base_out", 1'b0, xlate_r.hit)
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		`CHK("rst_tim", 17'h0e677, {tras_clocks_r, trp_clocks_r, trcd_clocks_r, trc_clocks_r, cas_latency_three_r})
		apb(1'b0, OFF_SPEED, 32'h0);
		`CHK("rst_spd", 32'hbf, q)
		apb(1'b0, OFF_USEC, 32'h0);
		`CHK("rst_usec", 32'h0, q)
		apb(1'b0, 8'h28, 32'h0);
		`CHK("rst_size", 32'h0, q)
		apb(1'b0, OFF_CLKDIV, 32'h0);
		`CHK("rst_div", 32'hf9, q)
		end_of_test();
	end
endmodule
`default_nettype wire
